/* hdl/lmp_device.sv */
// led matrix device end: two-wire target with paged register file
// Notes on behaviour
// - respond only while interface select is high
// - address byte: seven address bits, direction last
// - address 010, high pin, low pin codes
// - clock at most 1 MHz, open-drain data
// - sample data while clock high; idle released
// - data falling with clock high starts
// - ack whole ninth pulse on address match
// - controller stops when address not acknowledged
// - register address byte follows, gets acknowledged
// - data bytes msb first, each acknowledged
// - data rising with clock high stops
// - pointer increments during each data ack
// - read: write pointer, restart, read direction
// - controller selects page before page access
// - page values 0,1,2 pwm, scaling, function
// - page pointer powers up at pwm page
// - unlock key permits exactly one pointer write
// - unlock register readable, zero means locked
// - identification register returns own bus address
// - pwm and scaling bytes 01h-90h, zero reset
// - open/short bytes 03h-1ah read-only
// - write to 2fh on the function page restores every register
`timescale 1ns/1ns
`default_nettype none
module lmp_device
  import lmp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // link side
  lmp_link_if.dev link,
  // straps and select pins
  input wire logic iface_sel,
  input wire logic [1:0] high_address_select_pin,
  input wire logic [1:0] low_address_select_pin,
  // detection results from the led core
  input wire logic [OPEN_SHORT_COUNT-1:0][7:0] open_short_results,
  // register contents toward the led core
  output logic [1:0] page_sel,
  output logic [7:0] function_configuration,
  output logic [7:0] global_current_level,
  output logic [7:0] resistor_selection,
  output logic [7:0] temperature_status,
  output logic [7:0] spread_spectrum_control
);
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_REG, ST_WDATA, ST_RDATA} lmp_dev_state_t;
  logic [6:0] sync1_reg, sync2_reg, own_addr;
  logic scl_prev_reg, sda_prev_reg, scl_s, sda_s, en_s, scl_rise, scl_fall, start_det, stop_det;
  lmp_dev_state_t st_reg;
  logic [3:0] bit_cnt_reg;
  logic ack_phase_reg, rd_dir_reg, mst_ack_reg, sda_oe_reg, wr_stb_reg, sw_rst;
  logic [7:0] shift_reg, tx_reg, ptr_reg, wr_addr_reg, wr_data_reg, unlock_reg, rd_data, led_idx, os_idx;
  logic [1:0] page_reg;
  logic [7:0] pwm_mem [LED_COUNT];
  logic [7:0] scale_mem [LED_COUNT];
  logic [7:0] cfg_reg, glob_cur_reg, res_reg, temp_reg, ssc_reg;
  // two flops on every pin; edge history reads only the second, so no half-settled value leaks in
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_reg <= 7'h7f;
      sync2_reg <= 7'h7f;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      sync1_reg <= {link.scl, link.sda, iface_sel, high_address_select_pin, low_address_select_pin};
      sync2_reg <= sync1_reg;
      scl_prev_reg <= scl_s;
      sda_prev_reg <= sda_s;
    end
  end
  assign scl_s = sync2_reg[6];
  assign sda_s = sync2_reg[5];
  assign en_s = sync2_reg[4];
  assign own_addr = {ADDR_FIXED_BITS, sync2_reg[3:2], sync2_reg[1:0]};
  assign scl_rise = scl_s && !scl_prev_reg;
  assign scl_fall = !scl_s && scl_prev_reg;
  assign start_det = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
  assign stop_det = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;
  // bit engine: sample on rising clock, change data only after falling clock
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      ack_phase_reg <= 1'b0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      rd_dir_reg <= 1'b0;
      mst_ack_reg <= 1'b0;
      ptr_reg <= 8'h00;
      sda_oe_reg <= 1'b0;
      wr_stb_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      wr_data_reg <= 8'h00;
    end else begin
      wr_stb_reg <= 1'b0;
      if (!en_s || stop_det) begin
        st_reg <= ST_IDLE;
        ack_phase_reg <= 1'b0;
        sda_oe_reg <= 1'b0;
      end else if (start_det) begin
        st_reg <= ST_ADDR; // repeated start lands here too
        bit_cnt_reg <= 4'h0;
        ack_phase_reg <= 1'b0;
        sda_oe_reg <= 1'b0;
      end else if (scl_rise) begin
        if (!ack_phase_reg) begin
          shift_reg <= {shift_reg[6:0], sda_s}; // msb first
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end else begin
          mst_ack_reg <= !sda_s;
        end
      end else if (scl_fall && st_reg != ST_IDLE) begin
        if (!ack_phase_reg && bit_cnt_reg == BITS_PER_BYTE) begin
          ack_phase_reg <= 1'b1;
          case (st_reg)
            ST_ADDR: begin
              if (shift_reg[7:1] == own_addr) begin
                sda_oe_reg <= 1'b1; // held over the whole ninth pulse
                rd_dir_reg <= shift_reg[0];
              end else begin
                st_reg <= ST_IDLE; // stay released until next start
              end
            end
            ST_REG: begin
              ptr_reg <= shift_reg;
              sda_oe_reg <= 1'b1;
            end
            ST_WDATA: begin
              wr_stb_reg <= 1'b1;
              wr_addr_reg <= ptr_reg;
              wr_data_reg <= shift_reg;
              ptr_reg <= ptr_reg + 8'h01;
              sda_oe_reg <= 1'b1;
            end
            default: begin
              sda_oe_reg <= 1'b0; // controller answers this slot
            end
          endcase
        end else if (ack_phase_reg) begin
          ack_phase_reg <= 1'b0;
          bit_cnt_reg <= 4'h0;
          sda_oe_reg <= 1'b0;
          case (st_reg)
            ST_ADDR: begin
              if (rd_dir_reg == DIR_READ) begin
                st_reg <= ST_RDATA;
                tx_reg <= rd_data;
                ptr_reg <= ptr_reg + 8'h01;
                sda_oe_reg <= !rd_data[7];
              end else begin
                st_reg <= ST_REG;
              end
            end
            ST_REG: st_reg <= ST_WDATA;
            ST_RDATA: begin
              if (mst_ack_reg) begin
                tx_reg <= rd_data;
                ptr_reg <= ptr_reg + 8'h01;
                sda_oe_reg <= !rd_data[7];
              end else begin
                st_reg <= ST_IDLE; // no ack from controller ends the read
              end
            end
            default: st_reg <= st_reg;
          endcase
        end else if (st_reg == ST_RDATA) begin
          tx_reg <= {tx_reg[6:0], 1'b0};
          sda_oe_reg <= !tx_reg[6];
        end
      end
    end
  end
  assign sw_rst = wr_stb_reg && page_reg == PAGE_FUNCTION[1:0] && wr_addr_reg == REG_SOFTWARE_RESET;
  // page pointer and its one-shot unlock
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      page_reg <= PAGE_PWM[1:0];
      unlock_reg <= UNLOCK_RESET;
    end else if (sw_rst) begin
      page_reg <= PAGE_PWM[1:0];
      unlock_reg <= UNLOCK_RESET;
    end else if (wr_stb_reg && wr_addr_reg == REG_PAGE_POINTER_UNLOCK) begin
      unlock_reg <= wr_data_reg;
    end else if (wr_stb_reg && wr_addr_reg == REG_PAGE_POINTER && unlock_reg == UNLOCK_KEY) begin
      unlock_reg <= UNLOCK_RESET; // one attempt used up
      if (wr_data_reg <= PAGE_FUNCTION) page_reg <= wr_data_reg[1:0]; // reserved ignored
    end
  end
  assign led_idx = wr_addr_reg - LED_FIRST;
  // paged register file; a locked pointer write falls through untouched
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < LED_COUNT; i++) begin
        pwm_mem[i] <= LED_RESET;
        scale_mem[i] <= LED_RESET;
      end
      cfg_reg <= FUNCTION_CONFIGURATION_RESET;
      glob_cur_reg <= GLOBAL_CURRENT_LEVEL_RESET;
      res_reg <= RESISTOR_SELECTION_RESET;
      temp_reg <= TEMPERATURE_STATUS_RESET;
      ssc_reg <= SPREAD_SPECTRUM_CONTROL_RESET;
    end else if (sw_rst) begin
      for (int i = 0; i < LED_COUNT; i++) begin
        pwm_mem[i] <= LED_RESET;
        scale_mem[i] <= LED_RESET;
      end
      cfg_reg <= FUNCTION_CONFIGURATION_RESET;
      glob_cur_reg <= GLOBAL_CURRENT_LEVEL_RESET;
      res_reg <= RESISTOR_SELECTION_RESET;
      temp_reg <= TEMPERATURE_STATUS_RESET;
      ssc_reg <= SPREAD_SPECTRUM_CONTROL_RESET;
    end else if (wr_stb_reg && wr_addr_reg < REG_IDENTIFICATION) begin
      if (page_reg != PAGE_FUNCTION[1:0] && wr_addr_reg >= LED_FIRST && wr_addr_reg <= LED_LAST) begin
        if (page_reg == PAGE_PWM[1:0]) begin
          pwm_mem[led_idx] <= wr_data_reg;
        end else begin
          scale_mem[led_idx] <= wr_data_reg;
        end
      end else if (page_reg == PAGE_FUNCTION[1:0]) begin
        // open/short bytes have no write path
        case (wr_addr_reg)
          REG_FUNCTION_CONFIGURATION: cfg_reg <= wr_data_reg;
          REG_GLOBAL_CURRENT_LEVEL: glob_cur_reg <= wr_data_reg;
          REG_RESISTOR_SELECTION: res_reg <= wr_data_reg;
          REG_TEMPERATURE_STATUS: temp_reg <= wr_data_reg;
          REG_SPREAD_SPECTRUM_CONTROL: ssc_reg <= wr_data_reg;
          default: cfg_reg <= cfg_reg;
        endcase
      end
    end
  end
  // read mux at the pointer; unmapped and write-only offsets read zero
  always_comb begin
    os_idx = ptr_reg - REG_OPEN_SHORT_FIRST;
    rd_data = 8'h00;
    if (ptr_reg == REG_IDENTIFICATION) begin
      rd_data = {own_addr, DIR_WRITE};
    end else if (ptr_reg == REG_PAGE_POINTER_UNLOCK) begin
      rd_data = unlock_reg;
    end else if (page_reg != PAGE_FUNCTION[1:0]) begin
      if (ptr_reg >= LED_FIRST && ptr_reg <= LED_LAST) begin
        rd_data = (page_reg == PAGE_PWM[1:0]) ? pwm_mem[ptr_reg - LED_FIRST] : scale_mem[ptr_reg - LED_FIRST];
      end
    end else if (ptr_reg >= REG_OPEN_SHORT_FIRST && ptr_reg <= REG_OPEN_SHORT_LAST) begin
      rd_data = open_short_results[os_idx[4:0]];
    end else begin
      case (ptr_reg)
        REG_FUNCTION_CONFIGURATION: rd_data = cfg_reg;
        REG_GLOBAL_CURRENT_LEVEL: rd_data = glob_cur_reg;
        REG_RESISTOR_SELECTION: rd_data = res_reg;
        REG_TEMPERATURE_STATUS: rd_data = temp_reg;
        REG_SPREAD_SPECTRUM_CONTROL: rd_data = ssc_reg;
        default: rd_data = 8'h00;
      endcase
    end
  end
  // outputs straight from flops; data pin only ever pulls low
  assign link.sda_dev_out = 1'b0;
  assign link.sda_dev_oe = sda_oe_reg;
  assign page_sel = page_reg;
  assign function_configuration = cfg_reg;
  assign global_current_level = glob_cur_reg;
  assign resistor_selection = res_reg;
  assign temperature_status = temp_reg;
  assign spread_spectrum_control = ssc_reg;
endmodule
`default_nettype wire

/* hdl/lmp_pkg.sv */
// shared constants for the led matrix paged two-wire register port
package lmp_pkg;
  // target address layout
  localparam logic [2:0] ADDR_FIXED_BITS = 3'h2;
  localparam logic [1:0] SEL_GND = 2'h0;
  localparam logic [1:0] SEL_SCL = 2'h1;
  localparam logic [1:0] SEL_SDA = 2'h2;
  localparam logic [1:0] SEL_VCC = 2'h3;
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // register offsets common to all pages
  localparam logic [7:0] REG_IDENTIFICATION = 8'hfc;
  localparam logic [7:0] REG_PAGE_POINTER = 8'hfd;
  localparam logic [7:0] REG_PAGE_POINTER_UNLOCK = 8'hfe;

  // page values
  localparam logic [7:0] PAGE_PWM = 8'h00;
  localparam logic [7:0] PAGE_SCALING = 8'h01;
  localparam logic [7:0] PAGE_FUNCTION = 8'h02;
  localparam logic [7:0] UNLOCK_KEY = 8'hc5;
  localparam logic [7:0] UNLOCK_RESET = 8'h00;

  // per-led byte range on the pwm and scaling pages
  localparam logic [7:0] LED_FIRST = 8'h01;
  localparam logic [7:0] LED_LAST = 8'h90;
  localparam int LED_COUNT = 144;
  localparam logic [7:0] LED_RESET = 8'h00;

  // function page offsets and reset values
  localparam logic [7:0] REG_FUNCTION_CONFIGURATION = 8'h00;
  localparam logic [7:0] REG_GLOBAL_CURRENT_LEVEL = 8'h01;
  localparam logic [7:0] REG_RESISTOR_SELECTION = 8'h02;
  localparam logic [7:0] REG_OPEN_SHORT_FIRST = 8'h03;
  localparam logic [7:0] REG_OPEN_SHORT_LAST = 8'h1a;
  localparam int OPEN_SHORT_COUNT = 24;
  localparam logic [7:0] REG_TEMPERATURE_STATUS = 8'h24;
  localparam logic [7:0] REG_SPREAD_SPECTRUM_CONTROL = 8'h25;
  localparam logic [7:0] REG_SOFTWARE_RESET = 8'h2f;
  localparam logic [7:0] FUNCTION_CONFIGURATION_RESET = 8'h00;
  localparam logic [7:0] GLOBAL_CURRENT_LEVEL_RESET = 8'h00;
  localparam logic [7:0] RESISTOR_SELECTION_RESET = 8'h55;
  localparam logic [7:0] TEMPERATURE_STATUS_RESET = 8'h00;
  localparam logic [7:0] SPREAD_SPECTRUM_CONTROL_RESET = 8'h00;

  // timing: serial clock no faster than 1 MHz, built from four quarters
  localparam int CLK_PERIOD_NS = 50;
  localparam int SCL_MIN_PERIOD_NS = 1000;
  localparam int SCL_QUARTER_CYC = (SCL_MIN_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
endpackage

/* hdl/lmp_link_if.sv */
// two-wire link between the bus controller and the led matrix device
`timescale 1ns/1ns
`default_nettype none
interface lmp_link_if;
  logic scl;
  logic sda_host_out;
  logic sda_host_oe;
  logic sda_dev_out;
  logic sda_dev_oe;
  logic sda;

  // open-drain wire with pull-up: low whenever any end drives a zero
  assign sda = !((sda_host_oe && !sda_host_out) || (sda_dev_oe && !sda_dev_out));

  modport dev (input scl, input sda, output sda_dev_out, output sda_dev_oe);
  modport host (output scl, output sda_host_out, output sda_host_oe, input sda);
endinterface
`default_nettype wire

/* hdl/lmp_host.sv */
// bus controller end: single-byte register write and read over two wires
`timescale 1ns/1ns
`default_nettype none
module lmp_host
  import lmp_pkg::*;
#(
  parameter int QUARTER_CYC = SCL_QUARTER_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // link side
  lmp_link_if.host link,
  // command port
  input wire logic cmd_valid,
  input wire logic cmd_read,
  input wire logic [6:0] cmd_target,
  input wire logic [7:0] cmd_reg,
  input wire logic [7:0] cmd_wdata,
  output logic cmd_ready,
  // answer port
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_nack
);
  typedef enum logic [1:0] {H_IDLE, H_START, H_BITS, H_STOP} lmp_host_state_t;
  typedef enum logic [2:0] {SG_ADDR_W, SG_REG, SG_DATA, SG_ADDR_R, SG_RX} lmp_seg_t;

  logic sda1_reg;
  logic sda2_reg;
  logic [15:0] tick_cnt_reg;
  logic tick;
  lmp_host_state_t st_reg;
  lmp_seg_t seg_reg;
  logic [1:0] q_reg;
  logic [3:0] bit_reg;
  logic [7:0] tx_reg;
  logic [7:0] rx_reg;
  logic ack_ok_reg;
  logic rd_reg;
  logic [6:0] tgt_reg;
  logic [7:0] regaddr_reg;
  logic [7:0] wdata_reg;
  logic scl_reg;
  logic sda_oe_reg;
  logic ready_reg;
  logic rsp_valid_reg;
  logic [7:0] rsp_data_reg;
  logic nack_reg;

  // data pin is foreign to this clock
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sda1_reg <= 1'b1;
      sda2_reg <= 1'b1;
    end else begin
      sda1_reg <= link.sda;
      sda2_reg <= sda1_reg;
    end
  end

  // quarter-period tick; with the default SCL_QUARTER_CYC four quarters keep the clock at or below 1 MHz
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_reg <= 16'h0000;
    end else if (tick) begin
      tick_cnt_reg <= 16'h0000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 16'h0001;
    end
  end
  assign tick = tick_cnt_reg == 16'(QUARTER_CYC - 1);

  // transfer sequencer: q0 set data, q1 raise clock, q2 sample (start/stop: move data), q3 lower clock (stop: clock stays high)
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= H_IDLE;
      seg_reg <= SG_ADDR_W;
      q_reg <= 2'h0;
      bit_reg <= 4'h0;
      tx_reg <= 8'h00;
      rx_reg <= 8'h00;
      ack_ok_reg <= 1'b0;
      rd_reg <= 1'b0;
      tgt_reg <= 7'h00;
      regaddr_reg <= 8'h00;
      wdata_reg <= 8'h00;
      scl_reg <= 1'b1;
      sda_oe_reg <= 1'b0; // idle bus released high
      ready_reg <= 1'b0;
      rsp_valid_reg <= 1'b0;
      rsp_data_reg <= 8'h00;
      nack_reg <= 1'b0;
    end else begin
      rsp_valid_reg <= 1'b0;
      if (st_reg == H_IDLE) begin
        ready_reg <= !cmd_valid || !ready_reg;
        if (cmd_valid && ready_reg) begin
          rd_reg <= cmd_read;
          tgt_reg <= cmd_target;
          regaddr_reg <= cmd_reg;
          wdata_reg <= cmd_wdata;
          seg_reg <= SG_ADDR_W; // reads also begin with a write of the pointer
          nack_reg <= 1'b0;
          q_reg <= 2'h0;
          st_reg <= H_START;
        end
      end else if (tick) begin
        q_reg <= q_reg + 2'h1;
        unique case (st_reg)
          H_START: begin
            if (q_reg == 2'h0) sda_oe_reg <= 1'b0;
            if (q_reg == 2'h1) scl_reg <= 1'b1;
            if (q_reg == 2'h2) sda_oe_reg <= 1'b1; // fall with clock high
            if (q_reg == 2'h3) begin
              scl_reg <= 1'b0;
              st_reg <= H_BITS;
              bit_reg <= 4'h0;
              tx_reg <= {tgt_reg, (seg_reg == SG_ADDR_R) ? DIR_READ : DIR_WRITE};
            end
          end
          H_BITS: begin
            if (q_reg == 2'h0) begin
              // msb first; ack slot and received bits left released
              sda_oe_reg <= (bit_reg < BITS_PER_BYTE && seg_reg != SG_RX) ? !tx_reg[7] : 1'b0;
            end
            if (q_reg == 2'h1) scl_reg <= 1'b1;
            if (q_reg == 2'h2) begin
              if (bit_reg < BITS_PER_BYTE) rx_reg <= {rx_reg[6:0], sda2_reg};
              else ack_ok_reg <= !sda2_reg;
            end
            if (q_reg == 2'h3) begin
              scl_reg <= 1'b0;
              if (bit_reg < BITS_PER_BYTE) begin
                bit_reg <= bit_reg + 4'h1;
                tx_reg <= {tx_reg[6:0], 1'b0};
              end else if (seg_reg != SG_RX && !ack_ok_reg) begin
                nack_reg <= 1'b1;
                st_reg <= H_STOP; // abandon on missing ack
              end else begin
                bit_reg <= 4'h0;
                unique case (seg_reg)
                  SG_ADDR_W: begin
                    seg_reg <= SG_REG;
                    tx_reg <= regaddr_reg;
                  end
                  SG_REG: begin
                    if (rd_reg) begin
                      seg_reg <= SG_ADDR_R;
                      st_reg <= H_START; // repeated start
                    end else begin
                      seg_reg <= SG_DATA;
                      tx_reg <= wdata_reg;
                    end
                  end
                  SG_ADDR_R: seg_reg <= SG_RX;
                  default: st_reg <= H_STOP;
                endcase
              end
            end
          end
          H_STOP: begin
            if (q_reg == 2'h0) sda_oe_reg <= 1'b1;
            if (q_reg == 2'h1) scl_reg <= 1'b1;
            if (q_reg == 2'h2) sda_oe_reg <= 1'b0; // rise with clock high
            if (q_reg == 2'h3) begin
              st_reg <= H_IDLE;
              rsp_valid_reg <= 1'b1;
              rsp_data_reg <= rx_reg;
              ready_reg <= 1'b1;
            end
          end
          default: st_reg <= H_IDLE;
        endcase
      end
    end
  end

  // outputs from flops
  assign link.scl = scl_reg;
  assign link.sda_host_out = 1'b0;
  assign link.sda_host_oe = sda_oe_reg;
  assign cmd_ready = ready_reg;
  assign rsp_valid = rsp_valid_reg;
  assign rsp_data = rsp_data_reg;
  assign rsp_nack = nack_reg;
endmodule
`default_nettype wire

/* sim/lmp_link_properties.sv */
// wire-level checks on the two-wire link between controller and device
`timescale 1ns/1ns
`default_nettype none
module lmp_link_properties (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // link wires
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_host_oe,
  input wire logic sda_dev_oe
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // the rising-edge sample is skipped: the device may land a change there
  chk_dev_hold_high: assert property (scl && $past(scl) |-> $stable(sda_dev_oe))
    else $error("device moved sda while scl high");
  chk_scl_high_len: assert property ($rose(scl) |-> scl[*4])
    else $error("scl high phase too short");
  chk_scl_low_len: assert property ($fell(scl) |-> (!scl)[*4])
    else $error("scl low phase too short");
  chk_start_by_host: assert property ($fell(sda) && scl && $past(scl) |-> sda_host_oe)
    else $error("start not made by controller");
  chk_dev_edge_delay: assert property ($changed(sda_dev_oe) |-> !$past(scl, 3))
    else $error("device sda change not after scl fall");
  chk_stop_idle: assert property ($rose(sda) && scl && $past(scl) |=> (scl && !sda_dev_oe)[*4])
    else $error("bus not idle after stop");
  chk_ack_whole: assert property ($rose(scl) && sda_dev_oe |-> sda_dev_oe[*4])
    else $error("device ack dropped in pulse");
  chk_host_released: assert property (sda_dev_oe && scl |-> !sda_host_oe)
    else $error("controller drives during device slot");
endmodule
`default_nettype wire

/* sim/tb_top.sv */
// self-checking bench: controller end talks to the device end over the link
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import lmp_pkg::*;
  logic clk, rst_b, cmd_valid, cmd_read, cmd_ready, rsp_valid, rsp_nack, iface_sel;
  logic [6:0] cmd_target, own;
  logic [7:0] cmd_reg, cmd_wdata, rsp_data, fcfg, gcl, rsel, tstat, sscc;
  logic [1:0] page_sel, hi_sel, lo_sel;
  logic [OPEN_SHORT_COUNT-1:0][7:0] os_res;
  int error_cnt = 0;
  int samples_checked = 0;

  lmp_link_if lmp_link_if_i ();
  // quarter of 2 clk gives the 400 ns serial clock
  lmp_host #(.QUARTER_CYC(2)) lmp_host_i (.clk(clk), .rst_b(rst_b), .link(lmp_link_if_i), .cmd_valid(cmd_valid),
    .cmd_read(cmd_read), .cmd_target(cmd_target), .cmd_reg(cmd_reg), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack));
  lmp_device lmp_device_i (.clk(clk), .rst_b(rst_b), .link(lmp_link_if_i), .iface_sel(iface_sel),
    .high_address_select_pin(hi_sel), .low_address_select_pin(lo_sel), .open_short_results(os_res),
    .page_sel(page_sel), .function_configuration(fcfg), .global_current_level(gcl), .resistor_selection(rsel),
    .temperature_status(tstat), .spread_spectrum_control(sscc));
  lmp_link_properties lmp_link_properties_i (.clk(clk), .rst_b(rst_b), .scl(lmp_link_if_i.scl),
    .sda(lmp_link_if_i.sda), .sda_host_oe(lmp_link_if_i.sda_host_oe), .sda_dev_oe(lmp_link_if_i.sda_dev_oe));

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (error_cnt == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // one command, held until taken, then wait for the answer pulse
  task automatic xfer(input logic rd, input logic [6:0] tg, input logic [7:0] ra, input logic [7:0] wd,
                      input logic nk);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    check({7'h00, cmd_ready}, 8'h01);
    cmd_valid = 1'b1;
    cmd_read = rd;
    cmd_target = tg;
    cmd_reg = ra;
    cmd_wdata = wd;
    @(negedge clk);
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    check({7'h00, rsp_valid}, 8'h01);
    check({7'h00, rsp_nack}, {7'h00, nk});
    @(negedge clk);
  endtask

  task automatic wr(input logic [7:0] ra, input logic [7:0] wd);
    xfer(DIR_WRITE, own, ra, wd, 1'b0);
  endtask

  task automatic rd(input logic [7:0] ra, input logic [7:0] exp);
    xfer(DIR_READ, own, ra, 8'h00, 1'b0);
    check(rsp_data, exp);
  endtask

  // unlock, then move the page pointer
  task automatic pg(input logic [7:0] p);
    wr(REG_PAGE_POINTER_UNLOCK, UNLOCK_KEY);
    wr(REG_PAGE_POINTER, p);
  endtask

  initial begin
    rst_b = 1'b0;
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    cmd_target = 7'h00;
    cmd_reg = 8'h00;
    cmd_wdata = 8'h00;
    iface_sel = 1'b1;
    hi_sel = SEL_SDA;
    lo_sel = SEL_SCL;
    own = {ADDR_FIXED_BITS, SEL_SDA, SEL_SCL};
    for (int k = 0; k < OPEN_SHORT_COUNT; k++)
      os_res[k] = 8'(k) + 8'h40;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    check(rsel, RESISTOR_SELECTION_RESET); // reset value
    check({6'h00, page_sel}, PAGE_PWM);
    rd(REG_PAGE_POINTER_UNLOCK, UNLOCK_RESET);
    rd(REG_IDENTIFICATION, {own, DIR_WRITE});
    wr(REG_PAGE_POINTER, PAGE_FUNCTION); // locked write
    check({6'h00, page_sel}, PAGE_PWM);
    wr(REG_PAGE_POINTER_UNLOCK, UNLOCK_KEY);
    rd(REG_PAGE_POINTER_UNLOCK, UNLOCK_KEY);
    wr(REG_PAGE_POINTER, PAGE_FUNCTION);
    check({6'h00, page_sel}, PAGE_FUNCTION);
    rd(REG_PAGE_POINTER_UNLOCK, UNLOCK_RESET); // relocked
    wr(REG_PAGE_POINTER, PAGE_SCALING);
    check({6'h00, page_sel}, PAGE_FUNCTION); // only one write
    wr(REG_GLOBAL_CURRENT_LEVEL, 8'ha5);
    check(gcl, 8'ha5);
    rd(REG_GLOBAL_CURRENT_LEVEL, 8'ha5);
    wr(REG_OPEN_SHORT_LAST, 8'hff);
    rd(REG_OPEN_SHORT_LAST, os_res[OPEN_SHORT_COUNT-1]); // read-only
    pg(8'h03);
    check({6'h00, page_sel}, PAGE_FUNCTION); // reserved page
    pg(PAGE_PWM);
    wr(LED_LAST, 8'h3c);
    rd(LED_LAST, 8'h3c);
    rd(LED_FIRST, LED_RESET);
    pg(PAGE_SCALING);
    rd(LED_LAST, LED_RESET); // separate page
    xfer(DIR_WRITE, own ^ 7'h01, LED_FIRST, 8'h11, 1'b1); // foreign address
    iface_sel = 1'b0;
    xfer(DIR_READ, own, LED_FIRST, 8'h00, 1'b1); // deselected
    iface_sel = 1'b1;
    repeat (4) @(negedge clk);
    pg(PAGE_FUNCTION);
    wr(REG_RESISTOR_SELECTION, 8'h12);
    wr(REG_FUNCTION_CONFIGURATION, 8'h81);
    wr(REG_TEMPERATURE_STATUS, 8'h0c);
    wr(REG_SPREAD_SPECTRUM_CONTROL, 8'h30);
    check(rsel, 8'h12);
    check(fcfg, 8'h81);
    check(tstat, 8'h0c);
    check(sscc, 8'h30);
    rd(REG_SPREAD_SPECTRUM_CONTROL, 8'h30);
    wr(REG_SOFTWARE_RESET, 8'h00);
    check(rsel, RESISTOR_SELECTION_RESET); // soft reset
    check(fcfg, FUNCTION_CONFIGURATION_RESET);
    check(tstat, TEMPERATURE_STATUS_RESET);
    check(sscc, SPREAD_SPECTRUM_CONTROL_RESET);
    check(gcl, GLOBAL_CURRENT_LEVEL_RESET);
    check({6'h00, page_sel}, PAGE_PWM);
    // every strap code on both pins
    for (int i = 0; i < 4; i++) begin
      hi_sel = 2'(i);
      lo_sel = 2'(3 - i);
      repeat (4) @(negedge clk);
      own = {ADDR_FIXED_BITS, hi_sel, lo_sel};
      rd(REG_IDENTIFICATION, {own, DIR_WRITE});
    end
    summarize();
  end

  // cuts a hang well past the expected run length
  initial begin
    #2000000;
    error_cnt++;
    summarize();
  end
endmodule
`default_nettype wire
